// *** rtl/sdp_defs.vh ***
// Constants and field layout of the SPI datagram slave port.
// Summary of operation
// - Each frame is 40 bits: address byte then four data bytes.
// - Frame bit 39 is direction: 0 read, 1 write (address plus 0x80).
// - Every access moves a full 32-bit data word.
// - A full reply frame goes out in every transaction.
// - After a read, reply data is the register addressed by that read.
// - After a write, reply data echoes the write data received.
// - A read writes no register, but a read of address 0x00 pulses the status clear; its data bits are ignored.
// - Reply bits 39..32 are status; bit 7 zero, bit 0 reset flag.
// - Status bits 6 and 5 mirror left stop switch of motor 2 and 1.
// - Status bits 4 and 3 mirror velocity reached of motor 2 and 1.
// - Status bits 2 and 1 mirror driver fault 2 and 1 flags.
// - Register values sit right aligned in the 32-bit data field.
// - Input sampled on link clock rise, output changed after its fall.
// - Most significant bit first, bit 0 last, both directions.
// - Extra bits reappear on serial output delayed by 40 clocks.
// - Chip select rising edge takes shift register as the command if 40 or more bits came in.
// - With over 40 bits, only the last 40 form the command.
`ifndef SDP_DEFS_VH
`define SDP_DEFS_VH
`define SDP_FRAME_BITS 40
`define SDP_FRAME_MSB 39
`define SDP_DATA_MSB 31
`define SDP_ADDR_MSB 38
`define SDP_ADDR_LSB 32
`define SDP_DIR_BIT 39
`define SDP_CNT_W 6
`define SDP_CNT_FULL 6'h28
`define SDP_CNT_ZERO 6'h00
`define SDP_CNT_ONE 6'h01
`define SDP_GLOBAL_STATUS_REG_ADDR 7'h00
`define SDP_ZERO32 32'h00000000
`define SDP_ZERO40 40'h0000000000
`define SDP_ZERO7 7'h00
`define SDP_ST_RSVD 1'h0
`define SDP_BUF_W 39
`endif

// *** rtl/sdp_sync.v ***
// Two flip-flop synchroniser for one asynchronous level.
`timescale 1ns/1ps
module sdp_sync #(
  parameter RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // Asynchronous level in, synchronised level out
  input wire async_i,
  output reg sync_o
);

  reg meta;

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule

// *** rtl/sdp_buf2.v ***
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module sdp_buf2 #(
  parameter W = 39
) (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // Filling side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  // Draining side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o
);

  reg [W-1:0] mem [0:1];
  reg wr_ptr;
  reg rd_ptr;
  reg [1:0] fill;
  wire push;
  wire pop;

  assign in_ready_o = (fill != 2'h2);
  assign out_valid_o = (fill != 2'h0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fill <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push & ~pop) begin
        fill <= fill + 2'h1;
      end else if (pop & ~push) begin
        fill <= fill - 2'h1;
      end
    end
  end

endmodule

// *** rtl/sdp_spi_port.v ***
// SPI datagram slave port: shifter, frame decode, read pipeline, write queue.
`timescale 1ns/1ps
`include "sdp_defs.vh"
module sdp_spi_port (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // SPI pins
  input wire sck_i,
  input wire sdi_i,
  input wire chip_select_n_i,
  output reg sdo_o,
  output reg sdo_oe_o,
  // Status sources, same clock domain
  input wire [1:0] stop_left_i,
  input wire [1:0] vel_reached_i,
  input wire [1:0] drv_fault_i,
  input wire reset_flag_i,
  // Write command stream to the register file
  output reg wr_valid_o,
  input wire wr_ready_i,
  output reg [6:0] wr_addr_o,
  output reg [31:0] wr_data_o,
  // Read port of the register file
  output reg rd_req_o,
  output reg [6:0] rd_addr_o,
  input wire [31:0] rd_data_i,
  output reg global_status_reg_clear_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  wire sck_s;
  wire sdi_s;
  wire csn_s;
  reg sck_q;
  reg csn_q;
  wire sck_rise;
  wire sck_fall;
  wire cs_fall;
  wire cs_rise;

  sdp_sync #(.RESET_VAL(1'b0)) u_sync_sck (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i(sck_i),
    .sync_o(sck_s)
  );

  sdp_sync #(.RESET_VAL(1'b0)) u_sync_sdi (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i(sdi_i),
    .sync_o(sdi_s)
  );

  sdp_sync #(.RESET_VAL(1'b1)) u_sync_csn (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i(chip_select_n_i),
    .sync_o(csn_s)
  );

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_q <= 1'b0;
      csn_q <= 1'b1;
    end else begin
      sck_q <= sck_s;
      csn_q <= csn_s;
    end
  end

  // Edges are only seen if the link clock stays below half this clock.
  assign sck_rise = sck_s & ~sck_q & ~csn_s;
  assign sck_fall = ~sck_s & sck_q & ~csn_s;
  assign cs_fall = ~csn_s & csn_q;
  assign cs_rise = csn_s & ~csn_q;

  ////////////////////////////////////////////////////////////////////////////
  // Reply frame assembly and the single 40-bit shift register.

  reg [`SDP_FRAME_MSB:0] shreg;
  reg [`SDP_CNT_W-1:0] bit_cnt;
  reg [`SDP_DATA_MSB:0] reply_data;
  wire [7:0] status_byte;

  assign status_byte = {`SDP_ST_RSVD,
                        stop_left_i[1], stop_left_i[0],
                        vel_reached_i[1], vel_reached_i[0],
                        drv_fault_i[1], drv_fault_i[0],
                        reset_flag_i};

  // The reply is loaded at frame start; received bits push it out MSB first,
  // so bits past the 40th leave exactly 40 clocks later.
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shreg <= `SDP_ZERO40;
      bit_cnt <= `SDP_CNT_ZERO;
    end else if (cs_fall) begin
      shreg <= {status_byte, reply_data};
      bit_cnt <= `SDP_CNT_ZERO;
    end else if (sck_rise) begin
      shreg <= {shreg[`SDP_FRAME_MSB-1:0], sdi_s};
      if (bit_cnt != `SDP_CNT_FULL) begin
        bit_cnt <= bit_cnt + `SDP_CNT_ONE;
      end
    end
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end else begin
      sdo_oe_o <= ~csn_s;
      if (cs_fall) begin
        sdo_o <= status_byte[7];
      end else if (sck_fall) begin
        sdo_o <= shreg[`SDP_FRAME_MSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode at the end of a frame.

  wire frame_ok;
  wire frame_wr;
  wire [6:0] frame_addr;
  wire [31:0] frame_data;
  reg rd_pend;
  reg cmd_pend;
  reg [`SDP_BUF_W-1:0] cmd_word;
  wire buf_in_ready;
  wire buf_out_valid;
  wire buf_out_ready;
  wire [`SDP_BUF_W-1:0] buf_out_data;

  // Only full frames count; the last 40 bits are what the register holds.
  assign frame_ok = cs_rise & (bit_cnt == `SDP_CNT_FULL);
  assign frame_wr = shreg[`SDP_DIR_BIT];
  assign frame_addr = shreg[`SDP_ADDR_MSB:`SDP_ADDR_LSB];
  assign frame_data = shreg[`SDP_DATA_MSB:0];

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reply_data <= `SDP_ZERO32;
      rd_pend <= 1'b0;
      rd_req_o <= 1'b0;
      rd_addr_o <= `SDP_ZERO7;
      global_status_reg_clear_o <= 1'b0;
      cmd_pend <= 1'b0;
      cmd_word <= {`SDP_BUF_W{1'b0}};
    end else begin
      rd_req_o <= 1'b0;
      global_status_reg_clear_o <= 1'b0;
      rd_pend <= 1'b0;
      if (frame_ok & frame_wr) begin
        reply_data <= frame_data;
        cmd_word <= {frame_addr, frame_data};
        cmd_pend <= 1'b1;
      end else if (frame_ok) begin
        // A read fetches, and at address 0x00 pulses the status clear; its data bits are dropped.
        rd_req_o <= 1'b1;
        rd_addr_o <= frame_addr;
        rd_pend <= 1'b1;
        global_status_reg_clear_o <= (frame_addr == `SDP_GLOBAL_STATUS_REG_ADDR);
      end else if (cmd_pend & buf_in_ready) begin
        cmd_pend <= 1'b0;
      end
      if (rd_pend) begin
        reply_data <= rd_data_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write queue with registered output stage.

  sdp_buf2 #(.W(`SDP_BUF_W)) u_wr_buf (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .in_valid_i(cmd_pend),
    .in_ready_o(buf_in_ready),
    .in_data_i(cmd_word),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_out_ready),
    .out_data_o(buf_out_data)
  );

  assign buf_out_ready = ~wr_valid_o | wr_ready_i;

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_valid_o <= 1'b0;
      wr_addr_o <= `SDP_ZERO7;
      wr_data_o <= `SDP_ZERO32;
    end else if (buf_out_ready) begin
      wr_valid_o <= buf_out_valid;
      if (buf_out_valid) begin
        wr_addr_o <= buf_out_data[`SDP_BUF_W-1:`SDP_DATA_MSB+1];
        wr_data_o <= buf_out_data[`SDP_DATA_MSB:0];
      end
    end
  end

endmodule

// *** sim/sdp_spi_port_monitor.sv ***
// Checker of the SPI datagram slave port outputs.
`timescale 1ns/1ps
module sdp_spi_port_monitor (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // Watched ports
  input wire chip_select_n_i,
  input wire sdo_o,
  input wire sdo_oe_o,
  input wire wr_valid_o,
  input wire wr_ready_i,
  input wire [6:0] wr_addr_o,
  input wire [31:0] wr_data_o,
  input wire rd_req_o,
  input wire [6:0] rd_addr_o,
  input wire global_status_reg_clear_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence cs_idle;
    chip_select_n_i [*5];
  endsequence
  sequence cs_open;
    $fell(chip_select_n_i) ##0 !chip_select_n_i [*6];
  endsequence
  rd_pulse_a: assert property (rd_req_o |=> !rd_req_o)
    else $error("read pulse too long");
  global_status_reg_clr_a: assert property (global_status_reg_clear_o |->
    rd_req_o && rd_addr_o == 7'h00) else $error("bad status clear");
  wr_hold_a: assert property (wr_valid_o && !wr_ready_i |=>
    wr_valid_o && $stable(wr_addr_o) && $stable(wr_data_o))
    else $error("write dropped");
  oe_idle_a: assert property (cs_idle |-> !sdo_oe_o)
    else $error("output on while idle");
  oe_frame_a: assert property (cs_open |-> sdo_oe_o)
    else $error("output off in frame");
  stat_top_a: assert property ($rose(sdo_oe_o) |-> !sdo_o)
    else $error("status bit 7 set");
  rd_gap_a: assert property (rd_req_o |-> chip_select_n_i)
    else $error("read inside frame");
  wr_gap_a: assert property ($rose(wr_valid_o) |-> chip_select_n_i)
    else $error("write inside frame");
endmodule
bind sdp_spi_port sdp_spi_port_monitor i_mon (.core_clk_i, .rst_i,
  .chip_select_n_i, .sdo_o, .sdo_oe_o, .wr_valid_o, .wr_ready_i,
  .wr_addr_o, .wr_data_o, .rd_req_o, .rd_addr_o, .global_status_reg_clear_o);

// *** sim/sdp_master_model.sv ***
// Behavioural SPI master driving frames into the port.
`timescale 1ns/1ps
module sdp_master_model (
  // SPI pins
  output logic sck_o,
  output logic sdi_o,
  output logic chip_select_n_o,
  input wire logic sdo_i
);
  initial begin
    sck_o = 1'b1;
    sdi_o = 1'b0;
    chip_select_n_o = 1'b1;
  end
  // Sends the top n bits of d; idle data is inverted so it never looks held.
  task automatic frame(input int n, input logic [79:0] d,
                       output logic [79:0] r);
    r = '0;
    chip_select_n_o = 1'b0;
    #200;
    for (int i = 0; i < n; i++) begin
      sck_o = 1'b0;
      #40;
      sdi_o = d[79-i];
      #40;
      sck_o = 1'b1;
      r = {r[78:0], sdo_i};
      #80;
    end
    sdi_o = ~sdi_o;
    #100;
    chip_select_n_o = 1'b1;
    #400;
  endtask
endmodule

// *** sim/sdp_spi_port_tb.sv ***
// Self-checking bench of the SPI datagram slave port.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); end end
module sdp_spi_port_tb;
  logic core_clk_i, rst_i, sck, sdi, csn_n, sdo, sdo_oe;
  logic wr_ready, wr_valid, rd_req, gclr;
  logic [6:0] st, wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data, prevd;
  logic [39:0] c;
  logic [79:0] r;
  logic [38:0] wq[$], eq[$];
  int fail_count, checked, cyc, nclr, k;
  logic [39:0] cmd [6] = '{40'h2100000000, 40'h0000000000, 40'hA200ABCDEF,
    40'hA200123456, 40'h7F00000000, 40'h21FFFFFFFF};
  logic [6:0] sts [6] = '{7'h55, 7'h2A, 7'h7F, 7'h00, 7'h01, 7'h40};
  function automatic logic [31:0] rdv(input logic [6:0] a);
    return {a, ~a, 18'h2A5A5};
  endfunction
  assign rd_data = rdv(rd_addr);
  sdp_spi_port i_sdp_spi_port (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .sck_i(sck), .sdi_i(sdi), .chip_select_n_i(csn_n), .sdo_o(sdo),
    .sdo_oe_o(sdo_oe), .stop_left_i(st[6:5]), .vel_reached_i(st[4:3]),
    .drv_fault_i(st[2:1]), .reset_flag_i(st[0]), .wr_valid_o(wr_valid),
    .wr_ready_i(wr_ready), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
    .rd_req_o(rd_req), .rd_addr_o(rd_addr), .rd_data_i(rd_data),
    .global_status_reg_clear_o(gclr));
  sdp_master_model i_sdp_master_model (.sck_o(sck), .sdi_o(sdi),
    .chip_select_n_o(csn_n), .sdo_i(sdo));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc++;
    if (wr_valid && wr_ready) wq.push_back({wr_addr, wr_data});
    if (gclr) nclr++;
    if (cyc == 30000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic xfer(input int n, input logic [79:0] d,
                      input logic [6:0] s);
    @(posedge core_clk_i);
    #1;
    st = s;
    i_sdp_master_model.frame(n, d, r);
  endtask
  task automatic cmpq;
    repeat (20) @(posedge core_clk_i);
    `CHK(wq.size(), eq.size())
    foreach (eq[i]) `CHK(wq[i], eq[i])
    wq = {};
    eq = {};
  endtask
  task automatic finish_test;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    wr_ready = 1'b1;
    st = 7'h00;
    prevd = 32'h0;
    repeat (2) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    `CHK({sdo_oe, wr_valid, rd_req, gclr}, 4'h0)
    for (k = 0; k < 6; k++) begin
      xfer(40, {cmd[k], 40'h0}, sts[k]);
      `CHK(r[39:0], {1'b0, sts[k], prevd})
      prevd = cmd[k][39] ? cmd[k][31:0] : rdv(cmd[k][38:32]);
      if (cmd[k][39]) eq.push_back(cmd[k][38:0]);
    end
    cmpq();
    `CHK(nclr, 1)
    wr_ready = 1'b0;
    for (k = 0; k < 3; k++) begin
      c = {8'h90 + k[7:0], 32'h5A5A0000 + k};
      xfer(40, {c, 40'h0}, 7'h00);
      `CHK(r[39:0], {8'h00, prevd})
      prevd = c[31:0];
      eq.push_back(c[38:0]);
    end
    `CHK(wr_valid, 1'b1)
    @(posedge core_clk_i);
    #1 wr_ready = 1'b1;
    cmpq();
    xfer(20, {40'hBB12345678, 40'h0}, 7'h00);
    xfer(40, {40'h2100000000, 40'h0}, 7'h00);
    `CHK(r[39:0], {8'h00, prevd})
    prevd = rdv(7'h21);
    c = 40'hA3CAFEF00D;
    xfer(48, {8'hC3, c, 32'h0}, 7'h12);
    `CHK(r[47:0], {8'h12, prevd, 8'hC3})
    eq.push_back(c[38:0]);
    cmpq();
    finish_test();
  end
endmodule
